/* src/fpd_pkg.sv */
package fpd_pkg;
  localparam logic [3:0] COP_LINE = 4'hF;
  localparam logic [2:0] CP_ID_DEFAULT = 3'h1;
  localparam int FPR_COUNT = 8;
  // opmodes
  localparam logic [6:0] OPM_DIV = 7'h20;
  localparam logic [6:0] OPM_SDIV = 7'h60;
  localparam logic [6:0] OPM_DDIV = 7'h64;
  localparam logic [6:0] OPM_ETOX = 7'h10;
  localparam logic [6:0] OPM_ETOXM1 = 7'h08;
  // source formats
  localparam logic [2:0] FMT_L = 3'h0;
  localparam logic [2:0] FMT_S = 3'h1;
  localparam logic [2:0] FMT_X = 3'h2;
  localparam logic [2:0] FMT_P = 3'h3;
  localparam logic [2:0] FMT_W = 3'h4;
  localparam logic [2:0] FMT_D = 3'h5;
  localparam logic [2:0] FMT_B = 3'h6;
  // effective address modes and mode-7 subcodes
  localparam logic [2:0] EA_DREG = 3'h0;
  localparam logic [2:0] EA_AREG = 3'h1;
  localparam logic [2:0] EA_INDEXED = 3'h6;
  localparam logic [2:0] EA_EXT = 3'h7;
  localparam logic [2:0] EA_SUB_IMM = 3'h4;
  // exception byte bit positions
  localparam int EXC_BRANCH_UNORDERED_FLAG = 7;
  localparam int EXC_SIGNALING_NAN_FLAG = 6;
  localparam int EXC_OPERAND_ERROR_FLAG = 5;
  localparam int EXC_OVERFLOW_FLAG = 4;
  localparam int EXC_UNDERFLOW_FLAG = 3;
  localparam int EXC_DZ = 2;
  localparam int EXC_RESULT_INEXACT_FLAG = 1;
  localparam int EXC_DECIMAL_INPUT_INEXACT_FLAG = 0;
  // accrued byte bit positions
  localparam int ACC_IOP = 7;
  localparam int ACC_OVERFLOW_FLAG = 6;
  localparam int ACC_UNDERFLOW_FLAG = 5;
  localparam int ACC_DZ = 4;
  localparam int ACC_INEX = 3;
  // extended-precision constants
  localparam logic [14:0] EXT_BIAS = 15'h3FFF;
  localparam logic [14:0] EXT_EXP_MAX = 15'h7FFF;
  localparam logic [63:0] EXT_INF_MANT = 64'h8000_0000_0000_0000;
  localparam logic [79:0] EXT_ONE = 80'h3FFF_8000_0000_0000_0000;
  localparam logic [79:0] EXT_MONE = 80'hBFFF_8000_0000_0000_0000;
  localparam logic [79:0] EXT_QNAN = 80'h7FFF_FFFF_FFFF_FFFF_FFFF;
  localparam logic [79:0] EXT_RESET = 80'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  typedef enum logic [1:0] {PREC_CTRL, PREC_SGL, PREC_DBL} fpd_prec_type;
  typedef enum logic [1:0] {OP_DIV, OP_ETOX, OP_ETOXM1} fpd_op_type;
  typedef enum logic [1:0] {ST_IDLE, ST_CLASSIFY, ST_WAIT} fpd_state_type;
endpackage

/* src/fpd_class_if.sv */
`timescale 1ns/1ps
`default_nettype none
// operand class lines between the decoder and its classifiers
interface fpd_class_if;
  logic [79:0] operand;
  logic sign;
  logic is_zero;
  logic is_inf;
  logic is_nan;
  logic is_signaling_nan_flag;
  modport classifier(input operand, output sign, is_zero, is_inf, is_nan, is_signaling_nan_flag);
  modport user(output operand, input sign, is_zero, is_inf, is_nan, is_signaling_nan_flag);
endinterface
`default_nettype wire

/* src/fpd_classify.sv */
`timescale 1ns/1ps
`default_nettype none
module fpd_classify
  import fpd_pkg::*;
(
  fpd_class_if.classifier bus
);
  logic exp_max;
  logic frac_zero;

  // unnormals fall through as in-range; the arithmetic core normalises them
  assign exp_max = bus.operand[78:64] == EXT_EXP_MAX;
  assign frac_zero = bus.operand[62:0] == 63'h0;
  assign bus.sign = bus.operand[79];
  assign bus.is_zero = (bus.operand[78:0] == 79'h0);
  assign bus.is_inf = exp_max && frac_zero;
  assign bus.is_nan = exp_max && !frac_zero;
  assign bus.is_signaling_nan_flag = exp_max && !frac_zero && !bus.operand[62]; // quiet bit clear
endmodule
`default_nettype wire

/* src/fpd_fp_divide_exp_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module fpd_fp_divide_exp_decoder
  import fpd_pkg::*;
#(
  parameter logic [2:0] CP_ID = CP_ID_DEFAULT
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_word0,
  input wire logic [15:0] i_cmd_word1,
  input wire logic [95:0] i_mem_operand,
  input wire logic [1:0] i_ctrl_prec,
  input wire logic i_packed_unimpl_en,
  input wire logic i_packed_inex,
  input wire logic i_accrued_clr,
  input wire logic i_core_done,
  input wire logic [79:0] i_core_result,
  input wire logic i_core_overflow_flag,
  input wire logic i_core_underflow_flag,
  input wire logic i_core_inex,
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  output logic o_unimpl_type,
  output logic [79:0] o_result,
  output logic [2:0] o_result_reg,
  output logic [7:0] o_exc_byte,
  output logic [7:0] o_accrued_byte,
  output logic o_core_start,
  output logic [1:0] o_core_op,
  output logic [1:0] o_core_prec,
  output logic [79:0] o_core_src,
  output logic [79:0] o_core_dst
);
  fpd_state_type state_q;
  logic [79:0] fpr_q [FPR_COUNT];
  logic [79:0] src_q;
  logic [79:0] dst_q;
  fpd_op_type op_q;
  fpd_prec_type prec_q;
  logic [2:0] dreg_q;
  logic decimal_input_inexact_flag_q;

  logic frame_ok;
  logic rm;
  logic [2:0] spec;
  logic [2:0] dreg;
  logic [2:0] ea_mode;
  logic [2:0] ea_reg;
  logic op_ok;
  logic ea_ok;
  logic unimpl;
  fpd_op_type op_d;
  fpd_prec_type prec_d;
  logic [79:0] src_d;
  logic accept;

  logic sp_hit;
  logic [79:0] sp_res;
  logic sp_operand_error_flag;
  logic sp_dz;
  logic sp_signaling_nan_flag;
  logic sx;
  logic fin;
  logic [79:0] fin_res;
  logic [7:0] fin_exc;

  fpd_class_if src_c ();
  fpd_class_if dst_c ();

  assign src_c.operand = src_q;
  assign dst_c.operand = dst_q;

  fpd_classify u_src_class (
    .bus(src_c)
  );

  fpd_classify u_dst_class (
    .bus(dst_c)
  );

  // leading zero count for normalising a raw magnitude
  function automatic logic [6:0] lzc(input logic [63:0] m);
    logic found;
    lzc = 7'h40;
    found = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (!found && m[i]) begin
        lzc = 7'(63 - i);
        found = 1'b1;
      end
    end
  endfunction

  // value = m * 2**e, repacked as a normalised extended operand
  function automatic logic [79:0] norm(input logic s, input logic [63:0] m, input logic signed [15:0] e);
    logic [6:0] lz;
    logic signed [17:0] ex;
    lz = lzc(m);
    ex = $signed({3'b000, EXT_BIAS}) + 18'sd63 - $signed({11'h000, lz}) + 18'(e);
    norm = {s, ex[14:0], m << lz};
    if (m == 64'h0) begin
      norm = {s, 79'h0};
    end
  endfunction

  // widen any memory format to extended
  function automatic logic [79:0] cvt(input logic [2:0] f, input logic [95:0] d);
    logic [31:0] iv;
    logic [31:0] mag;
    cvt = {d[95:80], d[63:0]}; // extended image; packed arrives pre-converted
    iv = 32'h0;
    case (f)
      FMT_L, FMT_W, FMT_B: begin
        if (f == FMT_L) begin
          iv = d[31:0];
        end else if (f == FMT_W) begin
          iv = {{16{d[15]}}, d[15:0]};
        end else begin
          iv = {{24{d[7]}}, d[7:0]};
        end
        mag = iv[31] ? (~iv + 32'h1) : iv;
        cvt = norm(iv[31], {32'h0, mag}, 16'sh0);
      end
      FMT_S: begin
        if (d[30:23] == 8'hFF) begin
          cvt = {d[31], EXT_EXP_MAX, 1'b1, d[22:0], 40'h0};
        end else if (d[30:23] == 8'h00) begin
          cvt = norm(d[31], {41'h0, d[22:0]}, -16'sd149);
        end else begin
          cvt = norm(d[31], {40'h0, 1'b1, d[22:0]}, $signed({8'h00, d[30:23]}) - 16'sd150);
        end
      end
      FMT_D: begin
        if (d[62:52] == 11'h7FF) begin
          cvt = {d[63], EXT_EXP_MAX, 1'b1, d[51:0], 11'h0};
        end else if (d[62:52] == 11'h000) begin
          cvt = norm(d[63], {12'h0, d[51:0]}, -16'sd1074);
        end else begin
          cvt = norm(d[63], {11'h0, 1'b1, d[51:0]}, $signed({5'h00, d[62:52]}) - 16'sd1075);
        end
      end
      default: begin
      end
    endcase
  endfunction

  // a NaN result keeps its payload with the quiet bit forced
  function automatic logic [79:0] quiet(input logic [79:0] x);
    quiet = {x[79:63], 1'b1, x[61:0]};
  endfunction

  // field decode of the two instruction words
  always_comb begin
    frame_ok = (i_cmd_word0[15:12] == COP_LINE) && (i_cmd_word0[11:9] == CP_ID);
    frame_ok = frame_ok && (i_cmd_word0[8:6] == 3'h0) && !i_cmd_word1[15] && !i_cmd_word1[13];
    rm = i_cmd_word1[14];
    spec = i_cmd_word1[12:10];
    dreg = i_cmd_word1[9:7];
    ea_mode = i_cmd_word0[5:3];
    ea_reg = i_cmd_word0[2:0];
    op_ok = 1'b1;
    op_d = OP_DIV;
    prec_d = PREC_CTRL;
    case (i_cmd_word1[6:0])
      OPM_DIV: prec_d = PREC_CTRL;
      OPM_SDIV: prec_d = PREC_SGL;
      OPM_DDIV: prec_d = PREC_DBL;
      OPM_ETOX: op_d = OP_ETOX;
      OPM_ETOXM1: op_d = OP_ETOXM1;
      default: op_ok = 1'b0;
    endcase
    // address field only matters for a memory source; the fixed zero bits are checked in frame_ok
    ea_ok = 1'b1;
    if (rm) begin
      case (ea_mode)
        EA_DREG: ea_ok = (spec == FMT_L) || (spec == FMT_S) || (spec == FMT_W) || (spec == FMT_B);
        EA_AREG: ea_ok = 1'b0;
        EA_EXT: ea_ok = (ea_reg <= EA_SUB_IMM);
        default: ea_ok = 1'b1; // indirect forms and EA_INDEXED
      endcase
      if (spec > FMT_B) begin
        ea_ok = 1'b0;
      end
    end
    unimpl = rm && (spec == FMT_P) && i_packed_unimpl_en;
    src_d = rm ? cvt(spec, i_mem_operand) : fpr_q[spec];
    accept = i_ce && i_cmd_valid && (state_q == ST_IDLE);
  end

  // special operand table; anything not caught here goes to the core
  always_comb begin
    sp_hit = 1'b1;
    sp_res = EXT_QNAN;
    sp_operand_error_flag = 1'b0;
    sp_dz = 1'b0;
    sp_signaling_nan_flag = 1'b0;
    sx = src_c.sign ^ dst_c.sign;
    if (src_c.is_nan || (op_q == OP_DIV && dst_c.is_nan)) begin
      sp_res = (op_q == OP_DIV && dst_c.is_nan) ? quiet(dst_q) : quiet(src_q);
      sp_signaling_nan_flag = src_c.is_signaling_nan_flag || (op_q == OP_DIV && dst_c.is_signaling_nan_flag);
    end else if (op_q == OP_DIV) begin
      if ((src_c.is_zero && dst_c.is_zero) || (src_c.is_inf && dst_c.is_inf)) begin
        sp_operand_error_flag = 1'b1;
      end else if (src_c.is_zero) begin
        sp_res = {sx, EXT_EXP_MAX, EXT_INF_MANT};
        sp_dz = !dst_c.is_inf;
      end else if (dst_c.is_inf) begin
        sp_res = {sx, EXT_EXP_MAX, EXT_INF_MANT};
      end else if (src_c.is_inf || dst_c.is_zero) begin
        sp_res = {sx, 79'h0};
      end else begin
        sp_hit = 1'b0;
      end
    end else if (src_c.is_zero) begin
      sp_res = (op_q == OP_ETOX) ? EXT_ONE : src_q;
    end else if (src_c.is_inf) begin
      if (!src_c.sign) begin
        sp_res = src_q;
      end else begin
        sp_res = (op_q == OP_ETOX) ? EXT_RESET : EXT_MONE;
      end
    end else begin
      sp_hit = 1'b0;
    end
  end

  // completion and the exception byte it reports
  always_comb begin
    fin = (state_q == ST_CLASSIFY && sp_hit) || (state_q == ST_WAIT && i_core_done);
    fin_res = (state_q == ST_WAIT) ? i_core_result : sp_res;
    fin_exc = BYTE_RESET;
    fin_exc[EXC_SIGNALING_NAN_FLAG] = (state_q == ST_CLASSIFY) && sp_signaling_nan_flag;
    fin_exc[EXC_OPERAND_ERROR_FLAG] = (state_q == ST_CLASSIFY) && sp_operand_error_flag;
    fin_exc[EXC_DZ] = (state_q == ST_CLASSIFY) && sp_dz;
    fin_exc[EXC_OVERFLOW_FLAG] = (state_q == ST_WAIT) && i_core_overflow_flag;
    fin_exc[EXC_UNDERFLOW_FLAG] = (state_q == ST_WAIT) && i_core_underflow_flag;
    fin_exc[EXC_RESULT_INEXACT_FLAG] = (state_q == ST_WAIT) && i_core_inex;
    fin_exc[EXC_DECIMAL_INPUT_INEXACT_FLAG] = decimal_input_inexact_flag_q;
  end

  // sequencer: latch, classify, then either finish or wait on the core
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else if (i_ce) begin
      case (state_q)
        ST_IDLE: begin
          if (accept && frame_ok && op_ok && ea_ok && !unimpl) begin
            state_q <= ST_CLASSIFY;
          end
        end
        ST_CLASSIFY: state_q <= sp_hit ? ST_IDLE : ST_WAIT;
        ST_WAIT: begin
          if (i_core_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // operand and instruction latches, taken when a command is accepted
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      src_q <= EXT_RESET;
      dst_q <= EXT_RESET;
      op_q <= OP_DIV;
      prec_q <= PREC_CTRL;
      dreg_q <= 3'h0;
      decimal_input_inexact_flag_q <= 1'b0;
    end else if (accept) begin
      src_q <= src_d;
      dst_q <= fpr_q[dreg];
      op_q <= op_d;
      prec_q <= (prec_d == PREC_CTRL) ? fpd_prec_type'(i_ctrl_prec) : prec_d;
      dreg_q <= dreg;
      decimal_input_inexact_flag_q <= rm && (spec == FMT_P) && i_packed_inex;
    end
  end

  // data register file, written only on completion
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < FPR_COUNT; i++) begin
        fpr_q[i] <= EXT_RESET;
      end
    end else if (i_ce && fin) begin
      fpr_q[dreg_q] <= fin_res;
    end
  end

  // core request; held operands stay valid until the core answers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_core_start <= 1'b0;
      o_core_op <= 2'h0;
      o_core_prec <= 2'h0;
      o_core_src <= EXT_RESET;
      o_core_dst <= EXT_RESET;
    end else if (i_ce) begin
      o_core_start <= (state_q == ST_CLASSIFY) && !sp_hit;
      if (state_q == ST_CLASSIFY) begin
        o_core_op <= op_q;
        o_core_prec <= prec_q;
        o_core_src <= src_q;
        o_core_dst <= dst_q;
      end
    end
  end

  // status pulses and the result view
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_illegal <= 1'b0;
      o_unimpl_type <= 1'b0;
      o_result <= EXT_RESET;
      o_result_reg <= 3'h0;
      o_exc_byte <= BYTE_RESET;
    end else if (i_ce) begin
      o_busy <= (state_q == ST_IDLE) ? (accept && frame_ok && op_ok && ea_ok && !unimpl) : !fin;
      o_done <= fin;
      o_illegal <= accept && !(frame_ok && op_ok && ea_ok);
      o_unimpl_type <= accept && frame_ok && op_ok && ea_ok && unimpl;
      if (fin) begin
        o_result <= fin_res;
        o_result_reg <= dreg_q;
        o_exc_byte <= fin_exc;
      end
    end
  end

  // accrued byte is sticky; a new event beats a clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_accrued_byte <= BYTE_RESET;
    end else if (i_ce) begin
      o_accrued_byte <= (i_accrued_clr ? BYTE_RESET : o_accrued_byte) | (fin ? {
        fin_exc[EXC_BRANCH_UNORDERED_FLAG] | fin_exc[EXC_SIGNALING_NAN_FLAG] | fin_exc[EXC_OPERAND_ERROR_FLAG],
        fin_exc[EXC_OVERFLOW_FLAG],
        fin_exc[EXC_UNDERFLOW_FLAG] & fin_exc[EXC_RESULT_INEXACT_FLAG],
        fin_exc[EXC_DZ],
        fin_exc[EXC_DECIMAL_INPUT_INEXACT_FLAG] | fin_exc[EXC_RESULT_INEXACT_FLAG] | fin_exc[EXC_OVERFLOW_FLAG],
        3'h0} : BYTE_RESET);
    end
  end
endmodule
`default_nettype wire

/* tb/fpd_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural arithmetic core: answers a start after i_lat idle cycles
module fpd_core_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [1:0] i_op,
  input wire logic [79:0] i_src,
  input wire logic [79:0] i_dst,
  input wire logic [4:0] i_lat,
  input wire logic [2:0] i_flags,
  output logic o_done,
  output logic [79:0] o_result,
  output logic o_overflow_flag,
  output logic o_underflow_flag,
  output logic o_inex
);
  logic run_q;
  logic [4:0] cnt_q;
  logic [79:0] res_q;
  // latch operands on start; only the dst mantissa is folded in so results stay finite
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_q <= 1'b0;
      cnt_q <= 5'h00;
      res_q <= 80'h0;
    end else if (i_start) begin
      run_q <= 1'b1;
      cnt_q <= i_lat;
      res_q <= {i_src[79:2], i_op} ^ (i_op == 2'h0 ? {16'h0, i_dst[63:0]} : 80'h0);
    end else if (run_q) begin
      if (cnt_q == 5'h00) run_q <= 1'b0;
      else cnt_q <= cnt_q - 5'h01;
    end
  end
  // outside the done pulse the lines carry inverted junk, never a stale answer
  assign o_done = run_q && (cnt_q == 5'h00);
  assign o_result = o_done ? res_q : ~res_q;
  assign {o_overflow_flag, o_underflow_flag, o_inex} = o_done ? i_flags : ~i_flags;
endmodule
`default_nettype wire

/* tb/fpd_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module fpd_chk
  import fpd_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_accrued_clr,
  input wire logic i_core_done,
  input wire logic [79:0] i_core_result,
  input wire logic i_core_overflow_flag,
  input wire logic i_core_inex,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_illegal,
  input wire logic o_unimpl_type,
  input wire logic o_core_start,
  input wire logic [79:0] o_result,
  input wire logic [7:0] o_exc_byte,
  input wire logic [7:0] o_accrued_byte
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // a core answer while busy becomes a completion one edge later
  sequence s_core_answer;
    o_busy && i_core_done ##1 o_done;
  endsequence
  a_core_write: assert property (s_core_answer |-> o_result == $past(i_core_result))
    else $error("core result not written");
  a_core_flags: assert property (s_core_answer |-> o_exc_byte[EXC_OVERFLOW_FLAG] == $past(i_core_overflow_flag) && o_exc_byte[EXC_RESULT_INEXACT_FLAG] == $past(i_core_inex))
    else $error("core flags not copied");
  a_branch_unordered_flag_clear: assert property (o_done |-> !o_exc_byte[EXC_BRANCH_UNORDERED_FLAG])
    else $error("unordered flag set on completion");
  a_operand_error_flag_nan: assert property (o_done && o_exc_byte[EXC_OPERAND_ERROR_FLAG] |-> o_result == EXT_QNAN && !o_exc_byte[EXC_DZ])
    else $error("operand error without default nan");
  a_dz_infinity: assert property (o_done && o_exc_byte[EXC_DZ] |-> o_result[78:0] == {EXT_EXP_MAX, EXT_INF_MANT})
    else $error("divide by zero without infinity");
  a_done_pulse: assert property (o_done |-> !o_busy ##1 !o_done)
    else $error("done not a single pulse");
  a_illegal_quiet: assert property (o_illegal |-> !o_busy ##1 (!o_illegal && !o_core_start) ##1 !o_core_start)
    else $error("illegal command executed");
  a_unimpl_quiet: assert property (o_unimpl_type |-> (!o_done && !o_core_start) [*3])
    else $error("trapped packed source executed");
  a_accrued_dz: assert property (o_done && o_exc_byte[EXC_DZ] |=> o_accrued_byte[ACC_DZ])
    else $error("accrued divide by zero missing");
  a_accrued_hold: assert property ($fell(o_accrued_byte[ACC_IOP]) |-> $past(i_accrued_clr))
    else $error("accrued bit lost without clear");
  a_start_pulse: assert property (o_core_start |-> o_busy ##1 !o_core_start)
    else $error("core start not a single pulse");
endmodule
bind fpd_fp_divide_exp_decoder fpd_chk u_fpd_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_accrued_clr(i_accrued_clr), .i_core_done(i_core_done), .i_core_result(i_core_result),
  .i_core_overflow_flag(i_core_overflow_flag), .i_core_inex(i_core_inex), .o_busy(o_busy), .o_done(o_done),
  .o_illegal(o_illegal), .o_unimpl_type(o_unimpl_type), .o_core_start(o_core_start),
  .o_result(o_result), .o_exc_byte(o_exc_byte), .o_accrued_byte(o_accrued_byte));
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top;
  import fpd_pkg::*;
  localparam logic [79:0] PINF = {1'b0, EXT_EXP_MAX, EXT_INF_MANT};
  localparam logic [79:0] NINF = {1'b1, EXT_EXP_MAX, EXT_INF_MANT};
  localparam logic [79:0] NZERO = {1'b1, 79'h0};
  localparam logic [79:0] XTHREE = 80'h4000_C000_0000_0000_0000;
  localparam logic [95:0] XPINF = {1'b0, EXT_EXP_MAX, 16'h0, EXT_INF_MANT};
  localparam logic [95:0] XNINF = {1'b1, EXT_EXP_MAX, 16'h0, EXT_INF_MANT};
  localparam logic [95:0] XNZ = {1'b1, 95'h0};
  localparam logic [95:0] XSNAN = {1'b0, EXT_EXP_MAX, 16'h0, 64'h8000_0000_0000_0001};
  localparam logic [79:0] QSNAN = 80'h7FFF_C000_0000_0000_0001;
  logic ce = 1'b1;
  logic clk = 1'b0, rst = 1'b1, valid = 1'b0, unimpl_en = 1'b0, inex_in = 1'b1, acc_clr = 1'b0;
  logic [15:0] w0 = 16'h0000, w1 = 16'h0000;
  logic [95:0] mem = 96'h0;
  logic [1:0] cprec = 2'h0;
  logic [4:0] lat = 5'h00;
  logic [2:0] flags = 3'h0;
  logic busy, done, ill, unimpl, start, cdone, covf, cunf, cinx;
  logic [79:0] res, cres, csrc, cdst;
  logic [2:0] rreg;
  logic [7:0] exc, acc;
  logic [1:0] cop, cpr;
  int errors = 0, checks = 0;
  // 100 MHz core clock
  always #5 clk = ~clk;
  // device under test and its arithmetic core
  fpd_fp_divide_exp_decoder u_fpd_fp_divide_exp_decoder (.i_core_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_cmd_valid(valid), .i_cmd_word0(w0), .i_cmd_word1(w1), .i_mem_operand(mem), .i_ctrl_prec(cprec),
    .i_packed_unimpl_en(unimpl_en), .i_packed_inex(inex_in), .i_accrued_clr(acc_clr), .i_core_done(cdone),
    .i_core_result(cres), .i_core_overflow_flag(covf), .i_core_underflow_flag(cunf), .i_core_inex(cinx), .o_busy(busy),
    .o_done(done), .o_illegal(ill), .o_unimpl_type(unimpl), .o_result(res), .o_result_reg(rreg),
    .o_exc_byte(exc), .o_accrued_byte(acc), .o_core_start(start), .o_core_op(cop), .o_core_prec(cpr),
    .o_core_src(csrc), .o_core_dst(cdst));
  fpd_core_model u_fpd_core_model (.i_clk(clk), .i_rst(rst), .i_start(start), .i_op(cop), .i_src(csrc),
    .i_dst(cdst), .i_lat(lat), .i_flags(flags), .o_done(cdone), .o_result(cres), .o_overflow_flag(covf),
    .o_underflow_flag(cunf), .o_inex(cinx));
  function automatic logic [15:0] ea(input logic [2:0] m, input logic [2:0] r);
    return {COP_LINE, CP_ID_DEFAULT, 3'h0, m, r};
  endfunction
  function automatic logic [15:0] op(input logic rm, input logic [2:0] s, input logic [2:0] d,
                                     input logic [6:0] o);
    return {1'b0, rm, 1'b0, s, d, o};
  endfunction
  // one command with both words and operand, then wait for any completion pulse
  task issue(input logic [15:0] a, input logic [15:0] b, input logic [95:0] m);
    int n;
    @(negedge clk);
    valid = 1'b1;
    w0 = a;
    w1 = b;
    mem = m;
    @(negedge clk);
    valid = 1'b0;
    n = 0;
    while (!(done | ill | unimpl) && n < 100) begin
      @(negedge clk);
      n++;
    end
    // a command that never completes counts against the run
    if (n >= 100) begin
      errors++;
    end
  endtask
  task t_reset;
    `CHK({busy, done, ill, unimpl, start, exc, acc, res}, 101'h0)
    $display("test reset done");
  endtask
  task t_specials;
    logic [6:0] o[7] = '{OPM_ETOX, OPM_ETOX, OPM_ETOX, OPM_ETOXM1, OPM_ETOXM1, OPM_ETOX, OPM_ETOXM1};
    logic [5:0] e[7] = '{6'o20, 6'o74, 6'o60, 6'o70, 6'o50, 6'o00, 6'o71};
    logic [2:0] f[7] = '{FMT_X, FMT_X, FMT_X, FMT_X, FMT_X, FMT_B, FMT_X};
    logic [95:0] m[7] = '{96'h0, XPINF, XNINF, XNINF, XNZ, 96'h0, 96'h0};
    logic [79:0] x[7] = '{EXT_ONE, PINF, 80'h0, EXT_MONE, NZERO, EXT_ONE, 80'h0};
    for (int k = 0; k < 7; k++) begin
      issue(ea(e[k][5:3], e[k][2:0]), op(1'b1, f[k], 3'(k + 1), o[k]), m[k]);
      `CHK(res, x[k])
      `CHK(rreg, 3'(k + 1))
      `CHK(exc, 8'h00)
    end
    $display("test specials done");
  endtask
  // divide corner cases land in the table without the core
  task div_case(input logic [15:0] a, input logic [15:0] b, input logic [95:0] m,
                input logic [79:0] xr, input logic [7:0] xe);
    issue(a, b, m);
    `CHK(res, xr)
    `CHK(exc, xe)
  endtask
  task t_divide;
    div_case(ea(3'h0, 3'h0), op(1'b0, 3'h0, 3'h0, OPM_DIV), 96'h0, EXT_QNAN, 8'h20);
    div_case(ea(3'h2, 3'h0), op(1'b1, FMT_X, 3'h1, OPM_SDIV), XNZ, NINF, 8'h04);
    div_case(ea(3'h2, 3'h0), op(1'b1, FMT_X, 3'h1, OPM_DDIV), XPINF, EXT_QNAN, 8'h20);
    div_case(ea(3'h2, 3'h0), op(1'b1, FMT_X, 3'h7, OPM_DIV), XNINF, NZERO, 8'h00);
    div_case(ea(3'h2, 3'h0), op(1'b1, FMT_X, 3'h3, OPM_DIV), XSNAN, QSNAN, 8'h40);
    $display("test divide done");
  endtask
  // core path for every opmode, latency growing from prompt to slow
  task t_core;
    logic [6:0] om[5] = '{OPM_DIV, OPM_SDIV, OPM_DDIV, OPM_ETOX, OPM_ETOXM1};
    logic [1:0] xo[5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
    logic [1:0] xp[3] = '{2'h2, 2'h1, 2'h2};
    logic [79:0] prev, xr;
    issue(ea(3'h2, 3'h0), op(1'b1, FMT_X, 3'h1, OPM_ETOX), 96'h0);
    prev = EXT_ONE;
    cprec = 2'h2;
    for (int k = 0; k < 5; k++) begin
      lat = 5'(3 * k);
      flags = {k[0], k == 4, 1'b1};
      issue(ea(3'h7, 3'h4), op(1'b1, FMT_W, 3'h1, om[k]), 96'h3);
      xr = {XTHREE[79:2], xo[k]} ^ (k < 3 ? {16'h0, prev[63:0]} : 80'h0);
      `CHK(csrc, XTHREE)
      `CHK(cop, xo[k])
      if (k < 3) begin
        `CHK(cdst, prev)
        `CHK(cpr, xp[k])
      end
      `CHK(res, xr)
      `CHK(exc, {3'h0, flags[2:1], 1'b0, flags[0], 1'b0})
      prev = xr;
    end
    `CHK(acc, 8'hF8)
    acc_clr = 1'b1;
    @(negedge clk);
    acc_clr = 1'b0;
    `CHK(acc, 8'h00)
    $display("test core done");
  endtask
  task t_packed;
    unimpl_en = 1'b1;
    issue(ea(3'h2, 3'h0), op(1'b1, FMT_P, 3'h2, OPM_DIV), 96'h0);
    `CHK({unimpl, done, busy}, 3'h4)
    unimpl_en = 1'b0;
    issue(ea(3'h2, 3'h0), op(1'b1, FMT_P, 3'h2, OPM_ETOX), 96'h0);
    `CHK(res, EXT_ONE)
    `CHK(exc, 8'h01)
    $display("test packed done");
  endtask
  // bad line, id, fixed bits, address modes, format and opmode
  task t_illegal;
    logic [15:0] a[9] = '{16'hE210, 16'hF410, 16'hF250, 16'hF208, 16'hF200, 16'hF23D, 16'hF210, 16'hF210, 16'hF210};
    logic [15:0] b[9] = '{16'h4910, 16'h4910, 16'h4910, 16'h4910, 16'h4910, 16'h4910, 16'h5D10, 16'h497F, 16'h6910};
    for (int k = 0; k < 9; k++) begin
      issue(a[k], b[k], 96'h0);
      `CHK({ill, done, busy}, 3'h4)
    end
    $display("test illegal done");
  endtask
  // a frozen block ignores a waiting command until the enable returns
  task t_enable;
    @(negedge clk);
    ce = 1'b0;
    valid = 1'b1;
    w0 = ea(3'h2, 3'h0);
    w1 = op(1'b1, FMT_X, 3'h4, OPM_ETOXM1);
    mem = XPINF;
    repeat (3) @(negedge clk);
    `CHK({busy, done, ill, res}, {3'h0, EXT_ONE})
    ce = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    `CHK(busy, 1'b1)
    @(negedge clk);
    `CHK({done, busy, res}, {2'h2, PINF})
    $display("test enable done");
  endtask
  task report_and_stop;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // reset for ten cycles, then the scenarios in order
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_specials;
    t_divide;
    t_core;
    t_packed;
    t_illegal;
    t_enable;
    report_and_stop;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
